// [logic/ctrl_port_pkg.sv]
// package: shared constants, state types and register images of the control port
`default_nettype none
package ctrl_port_pkg;

  // ****************************************************************
  // register file
  // ****************************************************************
  localparam int                         REG_COUNT    = 7;
  localparam logic [4:0]                 REG_LAST     = 5'h06;
  localparam logic [REG_COUNT-1:0][7:0]  REG_DEFAULTS = {8'h10, 8'h10, 8'h10, 8'h10,
                                                         8'h00, 8'h20, 8'h80};

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam logic [1:0] W3_CHIP_ADDR  = 2'h2;
  localparam logic       W3_DIR_WRITE  = 1'b1;
  localparam logic [4:0] W3_FRAME_BITS = 5'h10;
  // idle pin image: data, shift clock and select high, power-down low
  localparam logic [6:0] PIN_IDLE      = 7'h07;
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h04;
  localparam logic [4:0] BIT_LAST      = 5'h07;
  localparam logic [4:0] ACK_SLOT      = 5'h08;
  localparam logic [2:0] IDX_READ_ADDR = 3'h3;
  localparam logic [2:0] IDX_READ_DATA = 3'h4;

  // ****************************************************************
  // host timing
  // ****************************************************************
  localparam int         CLK_PERIOD_NS     = 8;
  localparam int         W3_MIN_PERIOD_NS  = 200;
  localparam int         I2C_MIN_PERIOD_NS = 10000;
  localparam int         PDN_LOW_NS        = 1000;
  localparam logic [8:0] W3_QUARTER  = 9'((W3_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                         / (4 * CLK_PERIOD_NS));
  localparam logic [8:0] I2C_QUARTER = 9'((I2C_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                         / (4 * CLK_PERIOD_NS));
  localparam logic [7:0] PDN_CYCLES  = 8'((PDN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [5:0] {
    D_IDLE  = 6'h01,
    D_RX    = 6'h02,
    D_ACK   = 6'h04,
    D_TX    = 6'h08,
    D_RACK  = 6'h10,
    D_RNEXT = 6'h20
  } dev_state_type;

  typedef enum logic [5:0] {
    H_PDN   = 6'h01,
    H_IDLE  = 6'h02,
    H_START = 6'h04,
    H_BITS  = 6'h08,
    H_STOP  = 6'h10,
    H_W3    = 6'h20
  } host_state_type;

  typedef struct packed {
    logic [6:0]                s1;
    logic [6:0]                s2;
    logic [6:0]                s3;
    dev_state_type             st;
    logic [4:0]                bits;
    logic                      got;
    logic [1:0]                byte_idx;
    logic                      is_read;
    logic [15:0]               sh;
    logic [4:0]                ptr;
    logic                      oe;
    logic [REG_COUNT-1:0][7:0] regs;
  } dev_reg_type;

  localparam dev_reg_type DEV_RESET = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, st: D_IDLE,
                                        regs: REG_DEFAULTS, default: '0};

  typedef struct packed {
    host_state_type hst;
    logic [1:0]     q;
    logic [8:0]     div;
    logic [7:0]     cnt;
    logic           sync1;
    logic           sync2;
    logic           sel;
    logic           pdn_n;
    logic           csl;
    logic           sck;
    logic           d_o;
    logic           d_oe;
    logic           pend;
    logic           rd;
    logic           cur;
    logic [1:0]     strap;
    logic [4:0]     addr;
    logic [7:0]     data;
    logic [2:0]     idx;
    logic [4:0]     bitn;
    logic [15:0]    sh;
    logic           nack;
    logic           ready;
    logic           rsp_valid;
    logic [7:0]     rsp_data;
    logic           rsp_err;
  } host_reg_type;

  localparam host_reg_type HOST_RESET = '{hst: H_PDN, cnt: PDN_CYCLES - 8'h01,
                                          sck: 1'b1, csl: 1'b1, default: '0};

  // address counter step with roll-over past the last register
  function automatic logic [4:0] next_addr(input logic [4:0] a);
    return (a >= REG_LAST) ? 5'h00 : a + 5'h01;
  endfunction

endpackage
`default_nettype wire

// [logic/ctrl_port_if.sv]
// interface: pins between host controller and control port
`timescale 1ns/1ps
`default_nettype none
interface ctrl_port_if;
  logic iface_select;
  logic powerdown_reset_pin_n;
  logic ctrl_select_low;
  logic ctrl_shift_clock;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data_line;

  // shared data wire with pull-up: any enabled low driver wins
  assign data_line = ~((host_data_oe & ~host_data_o) | (dev_data_oe & ~dev_data_o));

  modport host (
    output iface_select,
    output powerdown_reset_pin_n,
    output ctrl_select_low,
    output ctrl_shift_clock,
    output host_data_o,
    output host_data_oe,
    input  data_line
  );

  modport device (
    input  iface_select,
    input  powerdown_reset_pin_n,
    input  ctrl_select_low,
    input  ctrl_shift_clock,
    output dev_data_o,
    output dev_data_oe,
    input  data_line
  );
endinterface
`default_nettype wire

// [logic/ctrl_port_device.sv]
// device end: 3-wire and two-wire register control port on the link clock
//
// Summary of operation
// - select pin low 3-wire, high two-wire
// - power-down low holds registers at defaults
// - power-down low ignores all register writes
// - host pulls power-down low in the same cycle it changes select
// - 3-wire is write only, no read-back
// - 3-wire frame: 10, 1, addr5, data8
// - sample on rising shift clock edge
// - 3-wire write commits on select rising
// - host shift clock at most 5 MHz
// - host uses register addresses 00h-06h only
// - two-wire standard mode, 100 kHz only
// - slave address 00100 plus two straps
// - on match acknowledge, direction picks read/write
// - write: register address byte, then data bytes
// - acknowledge every byte received in writes
// - address counter increments, 06h wraps to 00h
// - current read sends counter byte, increments
// - host ack continues read, nack stops
// - random read: dummy write, repeated start
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_device (
  input  wire logic                                    link_clk,
  input  wire logic                                    rst_n,
  ctrl_port_if.device                                  link,
  input  wire logic                                    bus_addr_strap_0,
  input  wire logic                                    bus_addr_strap_1,
  output logic [ctrl_port_pkg::REG_COUNT-1:0][7:0]     control_regs,
  output logic                                         two_wire_mode
);
  import ctrl_port_pkg::*;

  dev_reg_type r;
  dev_reg_type n;

  // ****************************************************************
  // synchronised pins and edges
  // ****************************************************************
  logic       sd;
  logic       sck;
  logic       csl;
  logic       pdn_n;
  logic       sel;
  logic [1:0] strap;
  logic       sck_rise;
  logic       sck_fall;
  logic       sd_rise;
  logic       sd_fall;
  logic       csl_rise;
  logic       csl_fall;
  logic [7:0] rd_byte;

  assign sd       = r.s2[0];
  assign sck      = r.s2[1];
  assign csl      = r.s2[2];
  assign pdn_n    = r.s2[3];
  assign sel      = r.s2[4];
  assign strap    = r.s2[6:5];
  assign sck_rise = sck & ~r.s3[1];
  assign sck_fall = ~sck & r.s3[1];
  assign sd_rise  = sd & ~r.s3[0];
  assign sd_fall  = ~sd & r.s3[0];
  assign csl_rise = csl & ~r.s3[2];
  assign csl_fall = ~csl & r.s3[2];
  assign rd_byte  = (r.ptr <= REG_LAST) ? r.regs[r.ptr] : 8'h00;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n    = r;
    n.s1 = {bus_addr_strap_1, bus_addr_strap_0, link.iface_select,
            link.powerdown_reset_pin_n, link.ctrl_select_low,
            link.ctrl_shift_clock, link.data_line};
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (!pdn_n) begin
      // registers forced to defaults, no write path open
      n.regs     = REG_DEFAULTS;
      n.st       = D_IDLE;
      n.oe       = 1'b0;
      n.bits     = 5'h00;
      n.got      = 1'b0;
      n.byte_idx = 2'h0;
    end else if (!sel) begin
      // 3-wire mode: data line never driven back
      n.oe = 1'b0;
      n.st = D_IDLE;
      if (csl_fall) begin
        n.bits = 5'h00;
        n.sh   = 16'h0000;
      end else if (!csl && sck_rise) begin
        n.sh = {r.sh[14:0], sd};
        if (r.bits != W3_FRAME_BITS) begin
          n.bits = r.bits + 5'h01;
        end
      end else if (csl_rise) begin
        if (r.bits == W3_FRAME_BITS && r.sh[15:14] == W3_CHIP_ADDR
            && r.sh[13] == W3_DIR_WRITE && r.sh[12:8] <= REG_LAST) begin
          n.regs[r.sh[12:8]] = r.sh[7:0];
        end
      end
    end else begin
      if (sck && sd_fall) begin
        // start or repeated start
        n.st       = D_RX;
        n.bits     = 5'h00;
        n.got      = 1'b0;
        n.byte_idx = 2'h0;
        n.oe       = 1'b0;
      end else if (sck && sd_rise) begin
        // stop
        n.st = D_IDLE;
        n.oe = 1'b0;
      end else begin
        case (r.st)
          D_RX: begin
            if (sck_rise) begin
              n.sh[7:0] = {r.sh[6:0], sd};
              n.bits    = r.bits + 5'h01;
              if (r.bits == BIT_LAST) begin
                n.got = 1'b1;
              end
            end else if (sck_fall && r.got) begin
              n.got  = 1'b0;
              n.bits = 5'h00;
              if (r.byte_idx == 2'h0) begin
                if (r.sh[7:1] == {SLAVE_ADDR_HI, strap}) begin
                  n.oe      = 1'b1;
                  n.is_read = r.sh[0];
                  n.st      = D_ACK;
                end else begin
                  n.st = D_IDLE;
                end
              end else if (r.byte_idx == 2'h1) begin
                n.ptr = r.sh[4:0];
                n.oe  = 1'b1;
                n.st  = D_ACK;
              end else begin
                if (r.ptr <= REG_LAST) begin
                  n.regs[r.ptr] = r.sh[7:0];
                end
                n.ptr = next_addr(r.ptr);
                n.oe  = 1'b1;
                n.st  = D_ACK;
              end
            end
          end
          D_ACK: begin
            if (sck_fall) begin
              n.oe   = 1'b0;
              n.bits = 5'h00;
              if (r.is_read) begin
                n.sh[7:0] = rd_byte;
                n.oe      = ~rd_byte[7];
                n.ptr     = next_addr(r.ptr);
                n.st      = D_TX;
              end else begin
                n.st = D_RX;
                if (r.byte_idx != 2'h2) begin
                  n.byte_idx = r.byte_idx + 2'h1;
                end
              end
            end
          end
          D_TX: begin
            if (sck_fall) begin
              if (r.bits == BIT_LAST) begin
                n.oe = 1'b0;
                n.st = D_RACK;
              end else begin
                n.sh[7:0] = {r.sh[6:0], 1'b0};
                n.oe      = ~r.sh[6];
                n.bits    = r.bits + 5'h01;
              end
            end
          end
          D_RACK: begin
            if (sck_rise) begin
              n.st = sd ? D_IDLE : D_RNEXT;
            end
          end
          D_RNEXT: begin
            if (sck_fall) begin
              n.bits    = 5'h00;
              n.sh[7:0] = rd_byte;
              n.oe      = ~rd_byte[7];
              n.ptr     = next_addr(r.ptr);
              n.st      = D_TX;
            end
          end
          default: begin
            n.oe = 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= DEV_RESET;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign control_regs     = r.regs;
  assign two_wire_mode    = r.s2[4];
  assign link.dev_data_oe = r.oe;
  assign link.dev_data_o  = 1'b0;

endmodule
`default_nettype wire

// [logic/ctrl_port_host.sv]
// host end: command-driven master for both control protocols
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_host (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  ctrl_port_if.host       link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_two_wire,
  input  wire logic       cmd_read,
  input  wire logic       cmd_current,
  input  wire logic [1:0] cmd_strap,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_data,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_error
);
  import ctrl_port_pkg::*;

  host_reg_type r;
  host_reg_type n;
  logic         tick;
  logic [8:0]   quarter;

  assign tick    = (r.div == 9'h000);
  assign quarter = r.sel ? I2C_QUARTER : W3_QUARTER;

  // byte sent in each slot of a two-wire transfer
  function automatic logic [7:0] byte_of(input logic [2:0] idx);
    case (idx)
      3'h0:    byte_of = {SLAVE_ADDR_HI, r.strap, 1'b0};
      3'h1:    byte_of = {3'h0, r.addr};
      3'h2:    byte_of = r.data;
      3'h3:    byte_of = {SLAVE_ADDR_HI, r.strap, 1'b1};
      default: byte_of = 8'hff;
    endcase
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n           = r;
    n.sync1     = link.data_line;
    n.sync2     = r.sync1;
    n.rsp_valid = 1'b0;
    n.div       = tick ? quarter - 9'h001 : r.div - 9'h001;
    if (tick) begin
      n.q = r.q + 2'h1;
    end
    case (r.hst)
      H_PDN: begin
        if (r.cnt != 8'h00) begin
          n.cnt = r.cnt - 8'h01;
        end else if (!r.pdn_n) begin
          n.pdn_n = 1'b1;
          n.cnt   = PDN_CYCLES - 8'h01;
        end else begin
          n.hst   = H_IDLE;
          n.ready = ~r.pend;
        end
      end
      H_IDLE: begin
        if (r.pend) begin
          n.pend = 1'b0;
          n.q    = 2'h0;
          n.div  = quarter - 9'h001;
          n.nack = 1'b0;
          if ((r.addr > REG_LAST && !(r.rd && r.cur)) || (!r.sel && r.rd)) begin
            n.ready     = 1'b1;
            n.rsp_valid = 1'b1;
            n.rsp_err   = 1'b1;
          end else if (!r.sel) begin
            n.csl  = 1'b0;
            n.sh   = {W3_CHIP_ADDR, W3_DIR_WRITE, r.addr, r.data};
            n.bitn = 5'h00;
            n.hst  = H_W3;
          end else begin
            n.idx = (r.rd && r.cur) ? IDX_READ_ADDR : 3'h0;
            n.hst = H_START;
          end
        end else if (cmd_valid && r.ready) begin
          n.ready = 1'b0;
          n.pend  = 1'b1;
          n.rd    = cmd_read;
          n.cur   = cmd_current;
          n.strap = cmd_strap;
          n.addr  = cmd_addr;
          n.data  = cmd_data;
          if (cmd_two_wire != r.sel) begin
            n.sel   = cmd_two_wire;
            n.pdn_n = 1'b0;
            n.cnt   = PDN_CYCLES - 8'h01;
            n.hst   = H_PDN;
          end
        end
      end
      H_START: begin
        if (tick) begin
          case (r.q)
            2'h0: n.sck = 1'b0;
            2'h1: n.d_oe = 1'b0;
            2'h2: n.sck = 1'b1;
            default: begin
              n.d_oe = 1'b1;
              n.hst  = H_BITS;
              n.bitn = 5'h00;
              n.sh   = {byte_of(r.idx), 8'h00};
            end
          endcase
        end
      end
      H_BITS: begin
        if (tick) begin
          case (r.q)
            2'h0: n.sck = 1'b0;
            2'h1: n.d_oe = (r.bitn == ACK_SLOT) ? 1'b0 : ~r.sh[15];
            2'h2: n.sck = 1'b1;
            default: begin
              if (r.bitn != ACK_SLOT) begin
                n.sh   = {r.sh[14:0], r.sync2};
                n.bitn = r.bitn + 5'h01;
              end else begin
                n.bitn = 5'h00;
                if (r.idx == IDX_READ_DATA) begin
                  n.rsp_data = r.sh[7:0];
                  n.hst      = H_STOP;
                end else if (r.sync2) begin
                  n.nack = 1'b1;
                  n.hst  = H_STOP;
                end else if (r.idx == 3'h2) begin
                  n.hst = H_STOP;
                end else if (r.idx == 3'h1 && r.rd) begin
                  n.idx = IDX_READ_ADDR;
                  n.hst = H_START;
                end else begin
                  n.idx = r.idx + 3'h1;
                  n.sh  = {byte_of(r.idx + 3'h1), 8'h00};
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          case (r.q)
            2'h0: n.sck = 1'b0;
            2'h1: n.d_oe = 1'b1;
            2'h2: n.sck = 1'b1;
            default: begin
              n.d_oe      = 1'b0;
              n.hst       = H_IDLE;
              n.ready     = 1'b1;
              n.rsp_valid = 1'b1;
              n.rsp_err   = r.nack;
            end
          endcase
        end
      end
      H_W3: begin
        if (tick) begin
          case (r.q)
            2'h0: n.sck = 1'b0;
            2'h1: begin
              n.d_oe = 1'b1;
              n.d_o  = r.sh[15];
            end
            2'h2: n.sck = 1'b1;
            default: begin
              n.sh   = {r.sh[14:0], 1'b0};
              n.bitn = r.bitn + 5'h01;
              if (r.bitn == W3_FRAME_BITS - 5'h01) begin
                n.csl       = 1'b1;
                n.d_oe      = 1'b0;
                n.d_o       = 1'b0;
                n.hst       = H_IDLE;
                n.ready     = 1'b1;
                n.rsp_valid = 1'b1;
                n.rsp_err   = 1'b0;
              end
            end
          endcase
        end
      end
      default: n.hst = H_IDLE;
    endcase
  end

  // ****************************************************************
  // state register and outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= HOST_RESET;
    end else begin
      r <= n;
    end
  end

  assign link.iface_select          = r.sel;
  assign link.powerdown_reset_pin_n = r.pdn_n;
  assign link.ctrl_select_low       = r.csl;
  assign link.ctrl_shift_clock      = r.sck;
  assign link.host_data_o           = r.d_o;
  assign link.host_data_oe          = r.d_oe;
  assign cmd_ready                  = r.ready;
  assign rsp_valid                  = r.rsp_valid;
  assign rsp_data                   = r.rsp_data;
  assign rsp_error                  = r.rsp_err;

endmodule
`default_nettype wire

// [sim/ctrl_port_assertions.sv]
// checker: link-level properties of the control port
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_assertions (
  input wire logic                                link_clk,
  input wire logic                                rst_n,
  input wire logic                                iface_select,
  input wire logic                                powerdown_reset_pin_n,
  input wire logic                                ctrl_select_low,
  input wire logic                                ctrl_shift_clock,
  input wire logic                                dev_data_oe,
  input wire logic                                data_line,
  input wire logic [ctrl_port_pkg::REG_COUNT-1:0][7:0] control_regs,
  input wire logic                                two_wire_mode
);
  import ctrl_port_pkg::*;

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge link_clk);
  endclocking
  default disable iff (!rst_n);

  mode_follow_a: assert property (
      $changed(iface_select) |-> ##[1:4] two_wire_mode == iface_select)
    else $error("mode does not follow select pin");
  pdn_default_a: assert property (
      (!powerdown_reset_pin_n) [*6] |-> control_regs == REG_DEFAULTS)
    else $error("registers not at defaults in power-down");
  pdn_hold_a: assert property (
      (!powerdown_reset_pin_n) [*6] |-> !dev_data_oe && $stable(control_regs))
    else $error("activity during power-down");
  three_wire_quiet_a: assert property (!two_wire_mode |-> !dev_data_oe)
    else $error("data line driven in 3-wire mode");
  low_drive_a: assert property (dev_data_oe |-> !data_line)
    else $error("device enable without low line");
  drive_on_low_a: assert property (
      $changed(dev_data_oe) |-> !ctrl_shift_clock)
    else $error("device data changed while clock high");
  frame_commit_a: assert property (
      (!two_wire_mode && !ctrl_select_low) [*8] |-> $stable(control_regs))
    else $error("register changed inside 3-wire frame");
  ack_hold_a: assert property ($rose(dev_data_oe) |-> dev_data_oe [*8])
    else $error("acknowledge too short");

  cover property ($rose(dev_data_oe));
  cover property ($rose(ctrl_select_low) && !two_wire_mode);
  cover property ($fell(powerdown_reset_pin_n));
endmodule
`default_nettype wire

// [sim/dual_mode_control_port_tb_top.sv]
// testbench: host end driving device end in both control modes
`timescale 1ns/1ps
`default_nettype none
module dual_mode_control_port_tb_top;
  import ctrl_port_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  typedef struct packed {
    logic       tw;
    logic       rd;
    logic       cur;
    logic [4:0] ad;
    logic [7:0] dt;
    logic       err;
    logic [7:0] rdat;
  } row_type;

  logic                        ref_clk = 1'b0;
  logic                        link_clk;
  logic                        rst_n = 1'b0;
  logic                        cmd_valid = 1'b0;
  logic                        cmd_ready;
  logic                        cmd_two_wire = 1'b0;
  logic                        cmd_read = 1'b0;
  logic                        cmd_current = 1'b0;
  logic [1:0]                  cmd_strap = 2'h0;
  logic [1:0]                  dev_strap = 2'h1;
  logic [4:0]                  cmd_addr = 5'h00;
  logic [7:0]                  cmd_data = 8'h00;
  logic                        rsp_valid;
  logic [7:0]                  rsp_data;
  logic                        rsp_error;
  logic [REG_COUNT-1:0][7:0]   control_regs;
  logic                        two_wire_mode;
  logic [REG_COUNT-1:0][7:0]   exp_regs;
  logic                        last_tw = 1'b0;
  int                          failures = 0;
  int                          cmp_count = 0;
  int                          cycle_count = 0;
  row_type rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 5'h00, 8'h55, 1'b0, 8'h00},
    '{1'b0, 1'b0, 1'b0, 5'h06, 8'h7f, 1'b0, 8'h00},
    '{1'b0, 1'b1, 1'b0, 5'h01, 8'h00, 1'b1, 8'h00},
    '{1'b0, 1'b0, 1'b0, 5'h07, 8'haa, 1'b1, 8'h00},
    '{1'b1, 1'b0, 1'b0, 5'h06, 8'h0c, 1'b0, 8'h00},
    '{1'b1, 1'b1, 1'b1, 5'h00, 8'h00, 1'b0, 8'h80}};

  ctrl_port_if link_bus ();

  always #4 ref_clk = ~ref_clk;
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  ctrl_port_host u_ctrl_port_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_two_wire(cmd_two_wire),
    .cmd_read(cmd_read), .cmd_current(cmd_current), .cmd_strap(cmd_strap),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error));
  ctrl_port_device u_ctrl_port_device (.link_clk(link_clk), .rst_n(rst_n), .link(link_bus),
    .bus_addr_strap_0(dev_strap[0]), .bus_addr_strap_1(dev_strap[1]),
    .control_regs(control_regs),
    .two_wire_mode(two_wire_mode));
  ctrl_port_assertions u_ctrl_port_assertions (.link_clk(link_clk), .rst_n(rst_n),
    .iface_select(link_bus.iface_select), .powerdown_reset_pin_n(link_bus.powerdown_reset_pin_n),
    .ctrl_select_low(link_bus.ctrl_select_low), .ctrl_shift_clock(link_bus.ctrl_shift_clock),
    .dev_data_oe(link_bus.dev_data_oe), .data_line(link_bus.data_line),
    .control_regs(control_regs), .two_wire_mode(two_wire_mode));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [55:0] exp, input logic [55:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run_cmd(input logic tw, input logic rd, input logic cur, input logic [1:0] st,
                         input logic [4:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_two_wire <= tw;
    cmd_read <= rd;
    cmd_current <= cur;
    cmd_strap <= st;
    cmd_addr <= ad;
    cmd_data <= dt;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 45000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 45000) failures++;
    repeat (24) @(posedge ref_clk);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  always @(posedge ref_clk) begin
    cycle_count++;
    if (cycle_count == 95000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    exp_regs = REG_DEFAULTS;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("reset regs", REG_DEFAULTS, control_regs);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      if (rows[i].tw !== last_tw) exp_regs = REG_DEFAULTS;
      last_tw = rows[i].tw;
      run_cmd(rows[i].tw, rows[i].rd, rows[i].cur, 2'h1, rows[i].ad, rows[i].dt);
      if (!rows[i].rd && !rows[i].err) exp_regs[rows[i].ad[2:0]] = rows[i].dt;
      check("regs", exp_regs, control_regs);
      check("mode", 56'(rows[i].tw), 56'(two_wire_mode));
      check("error", 56'(rows[i].err), 56'(rsp_error));
      if (rows[i].rd && !rows[i].err)
        check("rdata", 56'(rows[i].rdat), 56'(rsp_data));
      $display("row %0d done", i);
    end
    dev_strap <= 2'h2;
    run_cmd(1'b1, 1'b0, 1'b0, 2'h1, 5'h03, 8'h33);
    check("foreign error", 56'(1'b1), 56'(rsp_error));
    check("foreign regs", exp_regs, control_regs);
    $display("foreign address test done");
    test_done();
  end
endmodule
`default_nettype wire
